// File: rtl/bif_defines.vh
// Constants for the burst input framer: register map, resets, timing
`ifndef BIF_DEFINES_VH
`define BIF_DEFINES_VH

// -------------------------------------------------------------------
// Control bus framing
// -------------------------------------------------------------------
`define BIF_DEVADDR_HI 6'h01
`define BIF_WRITE_BIT 1'b0

// -------------------------------------------------------------------
// Register indices, one byte each
// -------------------------------------------------------------------
`define BIF_REG_CFG 5'h00
`define BIF_REG_DIV_LO 5'h01
`define BIF_REG_DIV_HI 5'h02
`define BIF_REG_PLEN 5'h03
`define BIF_REG_K 5'h04
`define BIF_REG_T 5'h05
`define BIF_REG_PRE0 5'h06
`define BIF_REG_LAST 5'h11
`define BIF_NREGS 18

// Field positions in the configuration byte
`define BIF_CFG_QAM 0
`define BIF_CFG_ECC 1

// -------------------------------------------------------------------
// Reset values
// -------------------------------------------------------------------
`define BIF_RST_CFG 8'h02
`define BIF_RST_DIV 16'h0010
`define BIF_RST_PLEN 8'h20
`define BIF_RST_K 8'h10
`define BIF_RST_T 8'h00

// -------------------------------------------------------------------
// Preamble and symbol timing, in bits; the gap in symbols
// -------------------------------------------------------------------
`define BIF_PRE_MAX 8'h60
`define BIF_RAMP_QPSK 8'h10
`define BIF_RAMP_QAM 8'h20
`define BIF_SYM2_QPSK 8'h04
`define BIF_SYM2_QAM 8'h08
`define BIF_GAP_SYMS 8'h05

// FIFO shape
`define BIF_FIFO_W 8
`define BIF_FIFO_D 16
`define BIF_FIFO_AW 4

`endif

// File: rtl/bif_fifo.v
// Byte FIFO holding sampled data while the preamble goes out
`timescale 1ns/1ps
module bif_fifo #(
   parameter W = 8,
   parameter D = 16,
   parameter AW = 4
) (
   // Clock and reset
   input wire ref_clk,
   input wire srst,
   // Fill side
   input wire wr_valid,
   input wire [W-1:0] wr_data,
   output wire wr_ready,
   // Drain side
   output wire rd_valid,
   output wire [W-1:0] rd_data,
   input wire rd_ready
);
   // -------------------------------------------------------------------
   // Storage and pointers
   // -------------------------------------------------------------------
   reg [W-1:0] mem_r [0:D-1]; // Word store
   reg [AW-1:0] wp_r; // Write index
   reg [AW-1:0] rp_r; // Read index
   reg [AW:0] cnt_r; // Occupancy
   wire do_wr;
   wire do_rd;

   // Full and empty come straight from the count, so both stay honest
   assign wr_ready = (cnt_r != D[AW:0]);
   assign rd_valid = (cnt_r != {(AW+1){1'b0}});
   assign rd_data = mem_r[rp_r];
   assign do_wr = wr_valid & wr_ready;
   assign do_rd = rd_valid & rd_ready;

   // Store write data; memory has no reset to keep it small
   always @(posedge ref_clk) begin
      if (do_wr) begin
         mem_r[wp_r] <= wr_data;
      end
   end

   // Pointer and count upkeep
   always @(posedge ref_clk) begin
      if (srst) begin
         wp_r <= {AW{1'b0}};
         rp_r <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wp_r <= wp_r + 1'b1;
         end
         if (do_rd) begin
            rp_r <= rp_r + 1'b1;
         end
         // Simultaneous push and pop leaves the count alone
         if (do_wr & ~do_rd) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (do_rd & ~do_wr) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule // bif_fifo

// File: rtl/bif_framer.v
// Burst input framer: control bus loader, gate sampler, frame sequencer
`timescale 1ns/1ps
`include "bif_defines.vh"

module bif_framer (
   // Clock and reset
   input wire ref_clk,
   input wire srst,
   // Control bus, byte level
   input wire ctl_start,
   input wire ctl_valid,
   input wire [7:0] ctl_byte,
   input wire addr_sel,
   // Burst input
   input wire tx_gate,
   input wire ser_din,
   // Modulator output
   output reg mod_bit_r,
   output reg mod_valid_r,
   output reg [1:0] mod_phase_r,
   output reg cw_start_r,
   output wire error_correction_mode,
   output wire qam_mode,
   // Status
   output reg gap_err_r,
   output reg ovf_err_r
);
   // -------------------------------------------------------------------
   // Local codes
   // -------------------------------------------------------------------
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_RAMP = 3'h1;
   localparam [2:0] ST_PRE = 3'h2;
   localparam [2:0] ST_DATA = 3'h3;
   localparam [2:0] ST_DOWN = 3'h4;
   localparam [1:0] BS_DEV = 2'h0;
   localparam [1:0] BS_REG = 2'h1;
   localparam [1:0] BS_DAT = 2'h2;
   localparam [1:0] BS_IGN = 2'h3;

   // -------------------------------------------------------------------
   // Register file and control bus loader
   // -------------------------------------------------------------------
   reg [7:0] regs_r [0:`BIF_NREGS-1]; // Configuration bytes
   reg [1:0] bs_r; // Bus byte phase
   reg [4:0] ptr_r; // Register pointer
   integer i;
   wire [15:0] rst_div; // Default bit period, split into two bytes

   assign rst_div = `BIF_RST_DIV;

   // Preamble bit i, msb of the first preamble byte goes first
   function pre_bit;
      input [6:0] idx;
      reg [4:0] byte_i;
      begin
         byte_i = `BIF_REG_PRE0 + {1'b0, idx[6:3]};
         pre_bit = regs_r[byte_i][3'h7 - idx[2:0]];
      end
   endfunction

   // Bytes after the start: address, pointer, then data
   always @(posedge ref_clk) begin
      if (srst) begin
         for (i = 0; i < `BIF_NREGS; i = i + 1) begin
            regs_r[i] <= 8'h00;
         end
         regs_r[`BIF_REG_CFG] <= `BIF_RST_CFG;
         regs_r[`BIF_REG_DIV_LO] <= rst_div[7:0];
         regs_r[`BIF_REG_DIV_HI] <= rst_div[15:8];
         regs_r[`BIF_REG_PLEN] <= `BIF_RST_PLEN;
         regs_r[`BIF_REG_K] <= `BIF_RST_K;
         regs_r[`BIF_REG_T] <= `BIF_RST_T;
         bs_r <= BS_IGN;
         ptr_r <= 5'h00;
      end else if (ctl_start) begin
         bs_r <= BS_DEV;
      end else if (ctl_valid) begin
         case (bs_r)
            BS_DEV: begin
               if (ctl_byte == {`BIF_DEVADDR_HI, addr_sel, `BIF_WRITE_BIT})
               begin
                  bs_r <= BS_REG;
               end else begin
                  bs_r <= BS_IGN;
               end
            end
            BS_REG: begin
               ptr_r <= ctl_byte[4:0];
               bs_r <= BS_DAT;
            end
            BS_DAT: begin
               if (ptr_r <= `BIF_REG_LAST) begin
                  regs_r[ptr_r] <= ctl_byte;
               end
               ptr_r <= ptr_r + 5'h01;
            end
            // Foreign transfer: wait for the next start
            default: begin
               bs_r <= BS_IGN;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Decoded settings
   // -------------------------------------------------------------------
   wire [15:0] bit_div;
   wire [15:0] half_div;
   wire [7:0] k_len;
   wire [7:0] cw_len;
   wire [7:0] ramp_len;
   wire [7:0] plen_raw;
   wire [7:0] pre_len;
   wire [7:0] gap_len;
   assign bit_div = {regs_r[`BIF_REG_DIV_HI], regs_r[`BIF_REG_DIV_LO]};
   assign half_div = {1'b0, bit_div[15:1]};
   assign qam_mode = regs_r[`BIF_REG_CFG][`BIF_CFG_QAM];
   assign error_correction_mode = regs_r[`BIF_REG_CFG][`BIF_CFG_ECC];
   assign k_len = regs_r[`BIF_REG_K];
   // parity slot in the gate is 2t bytes
   assign cw_len = error_correction_mode ?
                   k_len + {regs_r[`BIF_REG_T][6:0], 1'b0} : k_len;
   assign ramp_len = qam_mode ? `BIF_RAMP_QAM : `BIF_RAMP_QPSK;
   // preamble clipped to 96 bits and never shorter than ramp-up
   assign plen_raw = (regs_r[`BIF_REG_PLEN] > `BIF_PRE_MAX) ?
                     `BIF_PRE_MAX : regs_r[`BIF_REG_PLEN];
   assign pre_len = (plen_raw < ramp_len) ? ramp_len : plen_raw;
   // five symbols, two symbols being four or eight bits
   assign gap_len = qam_mode ? (`BIF_SYM2_QAM >> 1) * `BIF_GAP_SYMS :
                    (`BIF_SYM2_QPSK >> 1) * `BIF_GAP_SYMS;

   // -------------------------------------------------------------------
   // Gate edge detection and sampler
   // -------------------------------------------------------------------
   reg gate_d_r; // Gate one cycle ago
   reg samp_on_r; // Sampling a burst
   reg [15:0] stmr_r; // Cycles to the next sample
   reg [7:0] acc_r; // Byte being assembled
   reg [2:0] bcnt_r; // Bits in acc_r
   reg [7:0] icw_r; // Byte slot within codeword
   reg push_r; // FIFO write strobe
   reg [7:0] push_dat_r; // FIFO write byte
   reg [2:0] st_r; // Sequencer state
   wire gate_rise;
   wire start_ok;
   wire fifo_ready;

   // edge seen by comparing against the previous gate level
   assign gate_rise = tx_gate & ~gate_d_r;
   assign start_ok = gate_rise & (st_r == ST_IDLE) & ~samp_on_r;

   // Sampler: half period to the first sample, then every bit period
   always @(posedge ref_clk) begin
      if (srst) begin
         gate_d_r <= 1'b0;
         samp_on_r <= 1'b0;
         stmr_r <= 16'h0000;
         acc_r <= 8'h00;
         bcnt_r <= 3'h0;
         icw_r <= 8'h00;
         push_r <= 1'b0;
         push_dat_r <= 8'h00;
      end else begin
         gate_d_r <= tx_gate;
         push_r <= 1'b0;
         if (start_ok) begin
            // first sample half a period after the edge
            samp_on_r <= 1'b1;
            // The edge is seen a cycle late, so count one cycle less
            stmr_r <= (half_div == 16'h0000) ? 16'h0000 :
                      half_div - 16'h0001;
            bcnt_r <= 3'h0;
            icw_r <= 8'h00;
         end else if (samp_on_r & ~tx_gate) begin
            // End of burst: a partial byte leaves zero padded
            samp_on_r <= 1'b0;
            if (bcnt_r != 3'h0) begin
               push_r <= 1'b1;
               push_dat_r <= acc_r << (4'h8 - {1'b0, bcnt_r});
            end
         end else if (samp_on_r) begin
            if (stmr_r == 16'h0000) begin
               // then one sample per programmed period
               stmr_r <= bit_div - 16'h0001;
               acc_r <= {acc_r[6:0], ser_din};
               bcnt_r <= bcnt_r + 3'h1;
               if (bcnt_r == 3'h7) begin
                  // only the first K bytes of each slot are data
                  push_r <= (icw_r < k_len);
                  push_dat_r <= {acc_r[6:0], ser_din};
                  if (icw_r + 8'h01 >= cw_len) begin
                     icw_r <= 8'h00;
                  end else begin
                     icw_r <= icw_r + 8'h01;
                  end
               end
            end else begin
               stmr_r <= stmr_r - 16'h0001;
            end
         end
      end
   end

   // -------------------------------------------------------------------
   // Delay FIFO
   // -------------------------------------------------------------------
   wire rd_valid;
   wire [7:0] rd_data;
   wire rd_ready;
   reg [7:0] sh_r; // Output shifter
   reg [3:0] shn_r; // Bits left in shifter

   bif_fifo #(
      .W(`BIF_FIFO_W),
      .D(`BIF_FIFO_D),
      .AW(`BIF_FIFO_AW)
   ) i_bif_fifo (
      .ref_clk(ref_clk),
      .srst(srst),
      .wr_valid(push_r),
      .wr_data(push_dat_r),
      .wr_ready(fifo_ready),
      .rd_valid(rd_valid),
      .rd_data(rd_data),
      .rd_ready(rd_ready)
   );

   // Drain only in the data phase so the FIFO fills during preamble
   assign rd_ready = (st_r == ST_DATA) & (shn_r == 4'h0);

   // Overflow: a byte offered to a full FIFO is lost, so flag it
   always @(posedge ref_clk) begin
      if (srst) begin
         ovf_err_r <= 1'b0;
      end else if (push_r & ~fifo_ready) begin
         ovf_err_r <= 1'b1;
      end else if (start_ok) begin
         ovf_err_r <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Frame sequencer
   // -------------------------------------------------------------------
   reg [15:0] otmr_r; // Cycles to next output bit
   reg [7:0] ob_r; // Bit index from ramp-up start, restarted for ramp-down
   reg [7:0] ocw_r; // Output byte within codeword
   reg cw_pend_r; // Shifter holds a codeword's first byte
   wire ostb;

   assign ostb = (st_r != ST_IDLE) & (otmr_r == 16'h0000);

   // One bit per period: ramp-up, preamble, data, ramp-down
   always @(posedge ref_clk) begin
      if (srst) begin
         st_r <= ST_IDLE;
         otmr_r <= 16'h0000;
         ob_r <= 8'h00;
         ocw_r <= 8'h00;
         cw_pend_r <= 1'b0;
         sh_r <= 8'h00;
         shn_r <= 4'h0;
         mod_bit_r <= 1'b0;
         mod_valid_r <= 1'b0;
         mod_phase_r <= 2'h0;
         cw_start_r <= 1'b0;
         gap_err_r <= 1'b0;
      end else begin
         mod_valid_r <= 1'b0;
         cw_start_r <= 1'b0;
         if (st_r != ST_IDLE) begin
            otmr_r <= ostb ? bit_div - 16'h0001 : otmr_r - 16'h0001;
         end
         // a gate rise inside the guard is refused and flagged
         if (gate_rise & ~start_ok) begin
            gap_err_r <= 1'b1;
         end else if (start_ok) begin
            gap_err_r <= 1'b0;
         end
         // Shifter reload from the FIFO
         if (rd_ready & rd_valid) begin
            sh_r <= rd_data;
            shn_r <= 4'h8;
            cw_pend_r <= (ocw_r == 8'h00);
            ocw_r <= (ocw_r + 8'h01 >= k_len) ? 8'h00 : ocw_r + 8'h01;
         end
         case (st_r)
            ST_IDLE: begin
               if (start_ok) begin
                  st_r <= ST_RAMP;
                  otmr_r <= bit_div - 16'h0001;
                  ob_r <= 8'h00;
                  ocw_r <= 8'h00;
               end
            end
            ST_RAMP, ST_PRE: begin
               if (ostb) begin
                  mod_bit_r <= pre_bit(ob_r[6:0]);
                  mod_valid_r <= 1'b1;
                  mod_phase_r <= st_r[1:0];
                  ob_r <= ob_r + 8'h01;
                  if (ob_r + 8'h01 == ramp_len) begin
                     st_r <= ST_PRE;
                  end
                  // data waits the whole preamble bit count
                  if (ob_r + 8'h01 == pre_len) begin
                     st_r <= ST_DATA;
                  end
               end
            end
            ST_DATA: begin
               if (ostb) begin
                  if (shn_r != 4'h0) begin
                     // data bits follow with no gap
                     mod_bit_r <= sh_r[7];
                     mod_valid_r <= 1'b1;
                     mod_phase_r <= ST_DATA[1:0];
                     // mark the first bit of each codeword
                     cw_start_r <= cw_pend_r & (shn_r == 4'h8);
                     sh_r <= {sh_r[6:0], 1'b0};
                     shn_r <= shn_r - 4'h1;
                  end else if (~samp_on_r & ~push_r & ~rd_valid) begin
                     // burst over, first ramp-down bit goes now
                     // so the bit rhythm carries on without a hole
                     st_r <= ST_DOWN;
                     mod_bit_r <= 1'b0;
                     mod_valid_r <= 1'b1;
                     mod_phase_r <= 2'h0;
                     ob_r <= 8'h01;
                  end
               end
            end
            ST_DOWN: begin
               if (ostb) begin
                  // zeros for five symbols hold off the next burst
                  mod_bit_r <= 1'b0;
                  mod_valid_r <= 1'b1;
                  mod_phase_r <= 2'h0;
                  ob_r <= ob_r + 8'h01;
                  if (ob_r + 8'h01 == gap_len) begin
                     st_r <= ST_IDLE;
                  end
               end
            end
            default: begin
               st_r <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // bif_framer

// File: sim/bif_framer_properties.sv
// Checker for the burst input framer output sequencing
`timescale 1ns/1ps
module bif_framer_properties (
   // Clock and reset
   input wire ref_clk,
   input wire srst,
   // Inputs
   input wire ctl_start,
   input wire ctl_valid,
   input wire [7:0] ctl_byte,
   input wire addr_sel,
   input wire tx_gate,
   input wire ser_din,
   // Outputs
   input wire mod_bit_r,
   input wire mod_valid_r,
   input wire [1:0] mod_phase_r,
   input wire cw_start_r,
   input wire error_correction_mode,
   input wire qam_mode,
   input wire gap_err_r,
   input wire ovf_err_r
);
   // ---------------------------------------------------------------
   // Helper state
   // ---------------------------------------------------------------
   logic [1:0] last_ph_r; // Phase of the previous strobe
   logic [7:0] tail_cnt_r; // Ramp-down strobes since last data
   // Track phase history; bench keeps the bit period at 4 cycles
   always @(posedge ref_clk) begin
      if (srst) begin
         last_ph_r <= 2'h0;
         tail_cnt_r <= 8'h00;
      end else if (mod_valid_r) begin
         last_ph_r <= mod_phase_r;
         tail_cnt_r <= (mod_phase_r == 2'h0) ? tail_cnt_r + 8'h01 : 8'h00;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   property p_bit_spacing;
      mod_valid_r && mod_phase_r != 2'h0 |=> !mod_valid_r [*3] ##1 mod_valid_r;
   endproperty
   a_bit_spacing: assert property (p_bit_spacing)
      else $error("strobe spacing broken inside frame");
   property p_ramp_first;
      mod_valid_r && last_ph_r == 2'h0 && mod_phase_r != 2'h0
         |-> mod_phase_r == 2'h1;
   endproperty
   a_ramp_first: assert property (p_ramp_first)
      else $error("frame did not open with ramp-up");
   property p_pre_after;
      mod_valid_r && mod_phase_r == 2'h2 |-> last_ph_r inside {2'h1, 2'h2};
   endproperty
   a_pre_after: assert property (p_pre_after)
      else $error("preamble out of place");
   property p_data_after;
      mod_valid_r && mod_phase_r == 2'h3 && last_ph_r != 2'h3
         |-> last_ph_r inside {2'h1, 2'h2} && cw_start_r;
   endproperty
   a_data_after: assert property (p_data_after)
      else $error("data not right after preamble");
   property p_cw_bit;
      cw_start_r |-> mod_valid_r && mod_phase_r == 2'h3;
   endproperty
   a_cw_bit: assert property (p_cw_bit)
      else $error("codeword start off a data bit");
   property p_down_zero;
      mod_valid_r && mod_phase_r == 2'h0 |-> !mod_bit_r;
   endproperty
   a_down_zero: assert property (p_down_zero)
      else $error("ramp-down bit not zero");
   property p_tail_len;
      tail_cnt_r <= (qam_mode ? 8'd20 : 8'd10);
   endproperty
   a_tail_len: assert property (p_tail_len)
      else $error("ramp-down too long");
   property p_gap_set;
      $rose(gap_err_r) |-> $past(tx_gate) && !$past(tx_gate, 2);
   endproperty
   a_gap_set: assert property (p_gap_set)
      else $error("gap flag set without gate rise");
   property p_gap_clr;
      $fell(gap_err_r) |-> $past(tx_gate) && !$past(tx_gate, 2);
   endproperty
   a_gap_clr: assert property (p_gap_clr)
      else $error("gap flag cleared without burst start");
   property p_mode_hold;
      !$past(ctl_valid) && !$past(srst)
         |-> $stable(qam_mode) && $stable(error_correction_mode);
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("mode changed without bus byte");
   // Main scenarios reached
   c_qam_data: cover property (mod_valid_r && mod_phase_r == 2'h3 && qam_mode);
   c_gap: cover property ($rose(gap_err_r));
   c_cw: cover property (cw_start_r);
endmodule // bif_framer_properties

// File: sim/bif_host_model.sv
// Host model: sends gated serial bursts at the bit rate
`timescale 1ns/1ps
module bif_host_model #(
   parameter int DIV = 4
) (
   // Clock
   input wire ref_clk,
   // Burst link
   output logic tx_gate,
   output logic ser_din
);
   logic [63:0] pat; // Burst bits, first bit at the top
   int nbits; // Bits in the current burst
   int cyc; // Cycles into the burst
   initial begin
      tx_gate = 1'b0;
      ser_din = 1'b0;
      nbits = 0;
      cyc = 0;
   end
   // gate spans every byte; caller fills parity slots with ones
   always @(posedge ref_clk) begin
      if (cyc < nbits * DIV) begin
         tx_gate <= 1'b1;
         ser_din <= pat[63 - cyc / DIV];
         cyc <= cyc + 1;
      end else begin
         // Outside frames the line toggles so no stale bit looks valid
         tx_gate <= 1'b0;
         ser_din <= ~ser_din;
      end
   end
   // caller spaces bursts; back-to-back calls break it on purpose
   task send(input logic [63:0] p, input int n);
      @(posedge ref_clk);
      pat <= p;
      nbits <= n;
      cyc <= 0;
      repeat (n * DIV + 1) @(posedge ref_clk);
   endtask
endmodule // bif_host_model

// File: sim/test_bif_framer.sv
// Testbench for the burst input framer
`timescale 1ns/1ps
`include "bif_defines.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module test_bif_framer;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic ctl_start = 1'b0;
   logic ctl_valid = 1'b0;
   logic [7:0] ctl_byte = 8'h00;
   logic addr_sel = 1'b0;
   wire tx_gate, ser_din, mod_bit_r, mod_valid_r, cw_start_r;
   wire [1:0] mod_phase_r;
   wire error_correction_mode, qam_mode, gap_err_r, ovf_err_r;
   int bad_count = 0;
   int n_tests = 0;
   int n_cap = 0; // Strobes captured
   int cycles = 0; // Watchdog count
   logic cap_bit[128];
   logic [1:0] cap_ph[128];
   logic cap_cw[128];
   localparam logic [39:0] PRE = 40'ha53cf0965a; // Preamble bytes 6..10
   localparam logic [31:0] DAT = 32'hc3e17e81; // Two codewords, K=2
   always #2 ref_clk = ~ref_clk;
   bif_framer i_bif_framer (.ref_clk, .srst, .ctl_start, .ctl_valid,
      .ctl_byte, .addr_sel, .tx_gate, .ser_din, .mod_bit_r, .mod_valid_r,
      .mod_phase_r, .cw_start_r, .error_correction_mode, .qam_mode,
      .gap_err_r, .ovf_err_r);
   bif_host_model #(.DIV(4)) i_bif_host_model (.ref_clk, .tx_gate,
      .ser_din);
   // Capture up to 128 output strobes; watchdog against hangs
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         results();
      end
      if (mod_valid_r === 1'b1 && n_cap < 128) begin
         cap_bit[n_cap] = mod_bit_r;
         cap_ph[n_cap] = mod_phase_r;
         cap_cw[n_cap] = cw_start_r;
         n_cap++;
      end
   end
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // One bus byte or a start marker, held for one edge
   task ctl(input logic s, input logic [7:0] b);
      @(posedge ref_clk);
      ctl_start <= s;
      ctl_valid <= !s;
      ctl_byte <= b;
      @(posedge ref_clk);
      ctl_start <= 1'b0;
      ctl_valid <= 1'b0;
   endtask
   task results();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task t_reset();
      `CHK(qam_mode, 1'b0)
      `CHK(error_correction_mode, 1'b1)
      `CHK({gap_err_r, ovf_err_r, mod_valid_r}, 3'h0)
   endtask
   // Wrong device address: whole write ignored
   task t_refuse();
      ctl(1'b1, 8'h00);
      ctl(1'b0, 8'h06);
      ctl(1'b0, 8'h00);
      ctl(1'b0, 8'h03);
      @(posedge ref_clk);
      `CHK(qam_mode, 1'b0)
   endtask
   // One address then all bytes through the auto-incremented pointer
   task t_config(input logic [7:0] cfg, input logic [7:0] plen,
      input logic [7:0] t);
      logic [7:0] seq[14];
      seq = '{8'h06, 8'h00, cfg, 8'h04, 8'h00, plen, 8'h02, t,
         8'ha5, 8'h3c, 8'hf0, 8'h96, 8'h5a, 8'h00};
      addr_sel <= 1'b1;
      ctl(1'b1, 8'h00);
      for (int i = 0; i < 13; i++) ctl(1'b0, seq[i]);
      `CHK(qam_mode, cfg[0])
      `CHK(error_correction_mode, cfg[1])
   endtask
   // Full frame: ramp-up, preamble, two codewords, ramp-down
   // Parity slots in the pattern carry ones, which must never come out
   task t_burst(input int ramp, input int plen, input int tail,
      input logic [63:0] p, input int n);
      n_cap = 0;
      i_bif_host_model.send(p, n);
      repeat (400) @(posedge ref_clk);
      `CHK(n_cap, plen + 32 + tail)
      `CHK(gap_err_r, 1'b0)
      for (int i = 0; i < plen; i++) begin
         `CHK(cap_bit[i], PRE[39 - i])
         `CHK(cap_ph[i], (i < ramp) ? 2'h1 : 2'h2)
      end
      for (int j = 0; j < 32; j++) begin
         `CHK(cap_bit[plen + j], DAT[31 - j])
         `CHK(cap_ph[plen + j], 2'h3)
         `CHK(cap_cw[plen + j], (j % 16) == 0)
      end
      for (int k = plen + 32; k < n_cap; k++) begin
         `CHK({cap_ph[k], cap_bit[k]}, 3'h0)
      end
   endtask
   // Second gate rise while the first frame is still out: refused
   task t_gap();
      i_bif_host_model.send(64'h0, 8);
      i_bif_host_model.send({64{1'b1}}, 1);
      repeat (300) @(posedge ref_clk);
      `CHK(gap_err_r, 1'b1)
      `CHK(ovf_err_r, 1'b0)
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (16) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      t_reset();
      t_refuse();
      t_config(8'h00, 8'd24, 8'h00);
      t_burst(16, 24, 10, {DAT, 32'h0}, 32);
      t_gap();
      t_config(8'h03, 8'd40, 8'h01);
      t_burst(32, 40, 20, {DAT[31:16], 16'hffff, DAT[15:0], 16'hffff}, 64);
      results();
   end
endmodule // test_bif_framer
bind bif_framer bif_framer_properties i_bif_framer_properties (.ref_clk,
   .srst, .ctl_start, .ctl_valid, .ctl_byte, .addr_sel, .tx_gate, .ser_din,
   .mod_bit_r, .mod_valid_r, .mod_phase_r, .cw_start_r,
   .error_correction_mode, .qam_mode, .gap_err_r, .ovf_err_r);
